// ---- bench/mcsfr_core_model.sv ----
// Core-side model: direct SFR cycles and one-cycle execution requests.
// Assumes read data is registered one cycle after the address.
`timescale 1ns/1ns
module mcsfr_core_model
    import mcsfr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    input  wire logic       hit,
    output mcsfr_bus_s      bus,
    output mcsfr_exec_s     exec
);
    initial begin
        bus  = '0;
        exec = '0;
    end
    // Write taken at the edge after it is raised
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 bus = '{wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        #1 bus.wr = 1'b0;
    endtask
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d,
                          output logic h);
        @(posedge clk);
        #1 bus = '{wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1 d = rdata;
        h = hit;
    endtask
    task automatic run(input mcsfr_exec_s e);
        @(posedge clk);
        #1 exec = e;
        @(posedge clk);
        #1 exec = '0;
    endtask
endmodule // mcsfr_core_model

// ---- bench/mcsfr_core_props.sv ----
// Checker: port-level timing relations of the core SFR file.
// Assumes one clock domain and the registered outputs of the hand-over.
`timescale 1ns/1ns
module mcsfr_core_props
    import mcsfr_pkg::*;
(
    input wire logic                 MCLK,
    input wire logic                 RESETN,
    input wire mcsfr_bus_s           SFR_BUS,
    input wire mcsfr_exec_s          EXEC,
    input wire logic [7:0]           SFR_RDATA,
    input wire logic                 SFR_HIT,
    input wire logic [7:0]           ACC_VALUE,
    input wire logic [7:0]           PSW_VALUE,
    input wire logic [7:0]           STACK_PTR,
    input wire logic [15:0]          DATA_POINTER_VALUE,
    input wire logic [15:0]          PROG_CNT,
    input wire logic [7:0]           IND_HIGH_ADDR,
    input wire logic [4:0]           BANK_BASE,
    input wire logic                 BAUD_DOUBLE,
    input wire logic [7:0]           IRQ_CTRL,
    input wire logic [PIN_COUNT-1:0] DIO_IN,
    input wire logic [PIN_COUNT-1:0] DIO_OUT,
    input wire logic [PIN_COUNT-1:0] DIO_OE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    reset_clear_a: assert property (
        $rose(RESETN) |-> ACC_VALUE == 8'h00
        && PSW_VALUE == 8'h00 && IRQ_CTRL == 8'h00 && DIO_OE == '0
        && STACK_PTR == RST_STACK_PTR && PROG_CNT == RST_PROG_CNT)
        else $error("reset values wrong");
    parity_track_a: assert property ($changed(ACC_VALUE) |->
        ##[0:2] PSW_VALUE[PSW_PARITY] == ^ACC_VALUE)
        else $error("parity flag does not follow accumulator");
    bank_map_a: assert property ($changed(PSW_VALUE[4:3]) |->
        ##[0:2] BANK_BASE == {PSW_VALUE[4:3], 3'b000})
        else $error("bank base wrong");
    baud_bit_a: assert property (SFR_BUS.wr
        && SFR_BUS.addr == ADR_BAUD_CTRL
        |-> ##2 BAUD_DOUBLE == $past(SFR_BUS.wdata[BAUD_BIT], 2))
        else $error("baud bit wrong");
    sp_push_a: assert property (EXEC.push && !(SFR_BUS.wr
        && SFR_BUS.addr == ADR_STACK_POINTER)
        |-> ##2 STACK_PTR == $past(STACK_PTR) + 8'h01)
        else $error("stack pointer not pre-incremented");
    pc_step_a: assert property (EXEC.pc_inc && !EXEC.pc_load
        |-> ##2 PROG_CNT == $past(PROG_CNT) + 16'h0001)
        else $error("program counter did not step");
    pc_load_a: assert property (EXEC.pc_load
        |-> ##2 PROG_CNT == $past(EXEC.pc_value, 2))
        else $error("program counter load wrong");
    data_pointer_load_a: assert property (EXEC.data_pointer_load
        |-> ##2 DATA_POINTER_VALUE == $past(EXEC.data_pointer_value, 2))
        else $error("data pointer load wrong");
    pin_read_a: assert property (SFR_BUS.addr == ADR_PORT0_LATCH
        |=> SFR_HIT && SFR_RDATA == $past(DIO_IN[7:0]))
        else $error("port read does not show pins");

    cover property (EXEC.push);
    cover property (EXEC.alu_op == MCSFR_ALU_ADD);
    cover property (EXEC.pc_load);
    cover property (SFR_BUS.addr == ADR_PORT0_LATCH);
endmodule // mcsfr_core_props

bind mcsfr_core mcsfr_core_props i_props (.MCLK(MCLK), .RESETN(RESETN),
    .SFR_BUS(SFR_BUS), .EXEC(EXEC), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
    .ACC_VALUE(ACC_VALUE), .PSW_VALUE(PSW_VALUE), .STACK_PTR(STACK_PTR),
    .DATA_POINTER_VALUE(DATA_POINTER_VALUE), .PROG_CNT(PROG_CNT),
    .IND_HIGH_ADDR(IND_HIGH_ADDR), .BANK_BASE(BANK_BASE),
    .BAUD_DOUBLE(BAUD_DOUBLE), .IRQ_CTRL(IRQ_CTRL), .DIO_IN(DIO_IN),
    .DIO_OUT(DIO_OUT), .DIO_OE(DIO_OE));

// ---- bench/tb.sv ----
// Testbench: reference model of the SFR file compared at every result.
// Assumes the core model drives the bus; the bench drives the pins.
`timescale 1ns/1ns
module tb
    import mcsfr_pkg::*;
;
    logic                 mclk, resetn, hit, baud_v, c, h;
    mcsfr_bus_s           bus;
    mcsfr_exec_s          exec, e;
    logic [7:0]           rdata, acc_v, psw_v, sp_v, ind_v, irq_v, rv;
    logic [7:0]           a, b, o, d, m, ea, eb, ef;
    logic [15:0]          data_pointer_v, pc_v, p;
    logic [4:0]           bank_v;
    logic [PIN_COUNT-1:0] dio_in, dio_out, dio_oe;
    logic [23:0]          eo, ed, pv;
    logic [7:0]           adr [5];
    logic [7:0]           padr [3];
    logic [7:0]           dadr [3];
    int                   failures, compares, seed, i;

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    mcsfr_core i_dut (.MCLK(mclk), .RESETN(resetn), .SFR_BUS(bus),
        .EXEC(exec), .SFR_RDATA(rdata), .SFR_HIT(hit), .ACC_VALUE(acc_v),
        .PSW_VALUE(psw_v), .STACK_PTR(sp_v), .DATA_POINTER_VALUE(data_pointer_v),
        .PROG_CNT(pc_v), .IND_HIGH_ADDR(ind_v), .BANK_BASE(bank_v),
        .BAUD_DOUBLE(baud_v), .IRQ_CTRL(irq_v), .DIO_IN(dio_in),
        .DIO_OUT(dio_out), .DIO_OE(dio_oe));
    mcsfr_core_model i_core (.clk(mclk), .rdata(rdata), .hit(hit),
        .bus(bus), .exec(exec));

    task chk(input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task settle;
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task wr(input logic [7:0] x, input logic [7:0] y);
        i_core.sfr_wr(x, y);
        settle;
    endtask
    task rc(input logic [7:0] x, input logic [7:0] y);
        i_core.sfr_rd(x, rv, h);
        chk(rv, y);
    endtask
    task done(input string s);
        $display("test %s finished", s);
    endtask
    task give_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        give_verdict;
    end

    initial begin
        seed = 32'h984be0dc;
        failures = 0;
        compares = 0;
        resetn = 1'b0;
        dio_in = '0;
        repeat (12) @(posedge mclk);
        #1 resetn = 1'b1;
        chk(acc_v, 8'h00);
        chk(psw_v, 8'h00);
        chk(irq_v, 8'h00);
        chk(sp_v, RST_STACK_PTR);
        chk(pc_v, RST_PROG_CNT);
        chk(dio_oe, 22'h0);
        rc(ADR_IND_HIGH, RST_ZERO_BYTE);
        rc(ADR_MULDIV_B, RST_ZERO_BYTE);
        done("reset");
        adr = '{ADR_IND_HIGH, ADR_IRQ_CTRL, ADR_ACCUMULATOR, ADR_MULDIV_B,
                ADR_BAUD_CTRL};
        for (i = 0; i < 5; i++) begin
            d = $random(seed);
            wr(adr[i], d);
            rc(adr[i], i == 4 ? d & BAUD_MASK : d);
            chk(h, 1'b1);
        end
        chk(baud_v, d[7]);
        wr(ADR_IND_HIGH, d ^ 8'hff);
        chk(ind_v, d ^ 8'hff);
        rc(8'h8f, 8'h00);
        chk(h, 1'b0);
        done("registers");
        for (i = 0; i < 4; i++) begin
            a = $random(seed);
            d = $random(seed);
            d[4:3] = i[1:0];
            wr(ADR_ACCUMULATOR, a);
            wr(ADR_PSW, d);
            rc(ADR_PSW, {d[7:1], ^a});
            chk(bank_v, {i[1:0], 3'b000});
        end
        done("status");
        for (i = 0; i < 4; i++) begin
            a = $random(seed);
            b = $random(seed);
            o = $random(seed);
            c = $random(seed);
            if (i == 2 && b == 8'h00) b = 8'h01;
            if (i == 3) b = 8'h00;
            wr(ADR_ACCUMULATOR, a);
            wr(ADR_MULDIV_B, b);
            p = a + o + c;
            ef = {p[8], (a[3:0] + o[3:0] + c) > 5'd15, 3'b000,
                  a[7] == o[7] && p[7] != a[7], 2'b00};
            {ea, eb, m} = {p[7:0], b, 8'hc4};
            if (i == 1) begin
                p = a * b;
                {ea, eb, m} = {p[7:0], p[15:8], 8'h84};
                ef = {5'b00000, p[15:8] != 8'h00, 2'b00};
            end
            if (i == 2) {ea, eb, ef, m} = {a / b, a % b, 8'h00, 8'h80};
            if (i == 3) {ea, eb, ef, m} = {a, b, 8'h04, 8'h04};
            e = '0;
            e.alu_op = mcsfr_alu_e'(i < 3 ? i + 1 : 3);
            e.alu_cin = c;
            e.alu_operand = o;
            i_core.run(e);
            settle;
            chk(acc_v, ea);
            rc(ADR_MULDIV_B, eb);
            chk(psw_v & m, ef & m);
            chk(psw_v[0], ^ea);
        end
        done("arithmetic");
        e = '0;
        e.push = 1'b1;
        for (i = 8; i < 10; i++) begin
            i_core.run(e);
            settle;
            chk(sp_v, i[7:0]);
        end
        e = '0;
        e.pop = 1'b1;
        i_core.run(e);
        settle;
        chk(sp_v, 8'h08);
        e = '0;
        e.pc_inc = 1'b1;
        for (i = 1; i < 4; i++) begin
            i_core.run(e);
            settle;
            chk(pc_v, i[15:0]);
        end
        p = $random(seed);
        e.pc_load = 1'b1;
        e.pc_value = p;
        i_core.run(e);
        settle;
        chk(pc_v, p);
        done("stack and counter");
        p = $random(seed);
        e = '0;
        e.data_pointer_load = 1'b1;
        e.data_pointer_value = p;
        i_core.run(e);
        settle;
        chk(data_pointer_v, p);
        wr(ADR_DPTR0_LOW, p[7:0] ^ 8'hff);
        wr(ADR_DPTR0_HIGH, p[15:8] ^ 8'hff);
        chk(data_pointer_v, p ^ 16'hffff);
        wr(ADR_POINTER_SEL, 8'h01);
        chk(data_pointer_v, 16'h0000);
        wr(ADR_DPTR1_HIGH, p[7:0]);
        chk(data_pointer_v, {p[7:0], 8'h00});
        wr(ADR_POINTER_SEL, 8'h00);
        chk(data_pointer_v, p ^ 16'hffff);
        done("data pointer");
        padr = '{ADR_PORT0_LATCH, ADR_PORT1_LATCH, ADR_PORT2_LATCH};
        dadr = '{ADR_PORT0_DIR, ADR_PORT1_DIR, ADR_PORT2_DIR};
        eo = 24'h000000;
        ed = {8'h00, RST_PORT_LATCH, RST_PORT_LATCH};
        for (i = 0; i < 3; i++) begin
            a = i == 0 ? 8'hff : $random(seed);
            d = $random(seed);
            dio_in = 22'($random(seed));
            pv = {2'b00, dio_in};
            eo[8*i +: 8] = a;
            ed[8*i +: 8] = d;
            wr(dadr[i], a);
            wr(padr[i], d);
            chk(dio_oe, eo[21:0]);
            chk(dio_out, ed[21:0]);
            rc(padr[i], pv[8*i +: 8]);
        end
        done("ports");
        give_verdict;
    end
endmodule // tb

// ---- hw/mcsfr_core.sv ----
// Notes on behaviour
// - Reset clears interrupt request, status word, accumulator and B.
// - Byte at 0xBF, reset zero, gives high address for indirect moves.
// - Baud control at 0xD8 keeps only bit 7.
// - B is multiply/divide operand and result, else scratch byte.
// - Status: carry 7, half carry 6, user 5, overflow 2, user 1.
// - Status bits 4:3 pick register bank base 0x00/08/10/18.
// - Status bit 0 set when accumulator has odd ones count.
// - Stack pointer resets to 0x07, pre-incremented on push or call.
// - Data pointer loads as 16-bit value or separate bytes.
// - Program counter resets to zero, increments per fetched byte.
// - Latch ones drive pins high, zeros drive low.
// - Direction registers at 0xA2, 0x91, 0xA1; one means output.
// - Ports at 0x80, 0x90, 0xA0 serve pins 0-7, 8-15, 16-21.
// - Port reads return actual pin levels, outputs included.
// - Two data pointers; select register bit 0 picks one.
//
// Core SFR file and I/O ports of the 8-bit controller.
// Assumes the execution unit drives one SFR access per MCLK cycle.
`timescale 1ns/1ns
module mcsfr_core
    import mcsfr_pkg::*;
(
    input  wire logic                 MCLK,
    input  wire logic                 RESETN,
    input  wire mcsfr_bus_s           SFR_BUS,
    input  wire mcsfr_exec_s          EXEC,
    output logic [7:0]                SFR_RDATA,
    output logic                      SFR_HIT,
    output logic [7:0]                ACC_VALUE,
    output logic [7:0]                PSW_VALUE,
    output logic [7:0]                STACK_PTR,
    output logic [15:0]               DATA_POINTER_VALUE,
    output logic [15:0]               PROG_CNT,
    output logic [7:0]                IND_HIGH_ADDR,
    output logic [4:0]                BANK_BASE,
    output logic                      BAUD_DOUBLE,
    output logic [7:0]                IRQ_CTRL,
    input  wire logic [PIN_COUNT-1:0] DIO_IN,
    output logic [PIN_COUNT-1:0]      DIO_OUT,
    output logic [PIN_COUNT-1:0]      DIO_OE
);
    logic [7:0]  acc_r;
    logic [7:0]  b_r;
    logic [7:0]  psw_r;
    logic [7:0]  sp_r;
    logic [15:0] dptr0_r;
    logic [15:0] dptr1_r;
    logic        dps_r;
    logic [15:0] pc_r;
    logic [7:0]  ind_r;
    logic [7:0]  irq_r;
    logic [7:0]  baud_r;
    logic [7:0]  acc_nxt;
    logic [7:0]  b_nxt;
    logic        alu_carry;
    logic        alu_half;
    logic        alu_ovf;
    logic        alu_go;
    logic [7:0]  rdata_nxt;
    logic        hit_nxt;
    logic [2:0]  port_hit;
    logic [7:0]  port_rd0;
    logic [7:0]  port_rd1;
    logic [7:0]  port_rd2;
    logic        parity;

    function automatic logic wr_at(input logic [7:0] a);
        wr_at = SFR_BUS.wr && SFR_BUS.addr == a;
    endfunction

    assign alu_go = EXEC.alu_op != MCSFR_ALU_NONE;
    assign parity = ^acc_r;

    mcsfr_flags u_alu (
        .op      (EXEC.alu_op),
        .cin     (EXEC.alu_cin),
        .acc     (acc_r),
        .bval    (b_r),
        .operand (EXEC.alu_operand),
        .acc_nxt (acc_nxt),
        .b_nxt   (b_nxt),
        .carry   (alu_carry),
        .half    (alu_half),
        .ovf     (alu_ovf)
    );

    // Port 0, pins 0-7
    mcsfr_port #(
        .WIDTH     (8),
        .LATCH_RST (RST_PORT_LATCH),
        .LATCH_ADR (ADR_PORT0_LATCH),
        .DIR_ADR   (ADR_PORT0_DIR)
    ) u_port0 (
        .clk     (MCLK),
        .rst_n   (RESETN),
        .bus     (SFR_BUS),
        .pin_in  (DIO_IN[7:0]),
        .pin_out (DIO_OUT[7:0]),
        .pin_oe  (DIO_OE[7:0]),
        .hit     (port_hit[0]),
        .rdata   (port_rd0)
    );

    // Port 1, pins 8-15
    mcsfr_port #(
        .WIDTH     (8),
        .LATCH_RST (RST_PORT_LATCH),
        .LATCH_ADR (ADR_PORT1_LATCH),
        .DIR_ADR   (ADR_PORT1_DIR)
    ) u_port1 (
        .clk     (MCLK),
        .rst_n   (RESETN),
        .bus     (SFR_BUS),
        .pin_in  (DIO_IN[15:8]),
        .pin_out (DIO_OUT[15:8]),
        .pin_oe  (DIO_OE[15:8]),
        .hit     (port_hit[1]),
        .rdata   (port_rd1)
    );

    // Port 2, pins 16-21
    mcsfr_port #(
        .WIDTH     (PORT2_PINS),
        .LATCH_RST (RST_PORT2_LATCH),
        .LATCH_ADR (ADR_PORT2_LATCH),
        .DIR_ADR   (ADR_PORT2_DIR)
    ) u_port2 (
        .clk     (MCLK),
        .rst_n   (RESETN),
        .bus     (SFR_BUS),
        .pin_in  (DIO_IN[21:16]),
        .pin_out (DIO_OUT[21:16]),
        .pin_oe  (DIO_OE[21:16]),
        .hit     (port_hit[2]),
        .rdata   (port_rd2)
    );

    // Accumulator
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            acc_r <= RST_ZERO_BYTE;
        end else if (wr_at(ADR_ACCUMULATOR)) begin
            acc_r <= SFR_BUS.wdata;
        end else if (alu_go) begin
            acc_r <= acc_nxt;
        end
    end

    // B register
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            b_r <= RST_ZERO_BYTE;
        end else if (wr_at(ADR_MULDIV_B)) begin
            b_r <= SFR_BUS.wdata;
        end else if (alu_go) begin
            b_r <= b_nxt;
        end
    end

    // Status word; parity is never stored from software
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            psw_r <= RST_ZERO_BYTE;
        end else begin
            if (wr_at(ADR_PSW)) begin
                psw_r[7:1] <= SFR_BUS.wdata[7:1];
            end else if (alu_go) begin
                psw_r[PSW_OVERFLOW] <= alu_ovf;
                if (EXEC.alu_op == MCSFR_ALU_ADD) begin
                    psw_r[PSW_CARRY] <= alu_carry;
                    psw_r[PSW_HALF]  <= alu_half;
                end else begin
                    psw_r[PSW_CARRY] <= 1'b0;
                end
            end
            psw_r[PSW_PARITY] <= alu_go ? ^acc_nxt : parity;
        end
    end

    // Stack pointer
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            sp_r <= RST_STACK_PTR;
        end else if (wr_at(ADR_STACK_POINTER)) begin
            sp_r <= SFR_BUS.wdata;
        end else if (EXEC.push) begin
            sp_r <= sp_r + 8'h01;
        end else if (EXEC.pop) begin
            sp_r <= sp_r - 8'h01;
        end
    end

    // Data pointers and select
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            dptr0_r <= {RST_ZERO_BYTE, RST_ZERO_BYTE};
            dptr1_r <= {RST_ZERO_BYTE, RST_ZERO_BYTE};
        end else begin
            if (EXEC.data_pointer_load && !dps_r) begin
                dptr0_r <= EXEC.data_pointer_value;
            end else if (wr_at(ADR_DPTR0_LOW)) begin
                dptr0_r[7:0] <= SFR_BUS.wdata;
            end else if (wr_at(ADR_DPTR0_HIGH)) begin
                dptr0_r[15:8] <= SFR_BUS.wdata;
            end
            if (EXEC.data_pointer_load && dps_r) begin
                dptr1_r <= EXEC.data_pointer_value;
            end else if (wr_at(ADR_DPTR1_LOW)) begin
                dptr1_r[7:0] <= SFR_BUS.wdata;
            end else if (wr_at(ADR_DPTR1_HIGH)) begin
                dptr1_r[15:8] <= SFR_BUS.wdata;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            dps_r <= 1'b0;
        end else if (wr_at(ADR_POINTER_SEL)) begin
            dps_r <= SFR_BUS.wdata[0];
        end
    end

    // Program counter
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            pc_r <= RST_PROG_CNT;
        end else if (EXEC.pc_load) begin
            pc_r <= EXEC.pc_value;
        end else if (EXEC.pc_inc) begin
            pc_r <= pc_r + 16'h0001;
        end
    end

    // Indirect high address, interrupt request, baud control
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            ind_r  <= RST_ZERO_BYTE;
            irq_r  <= RST_ZERO_BYTE;
            baud_r <= RST_ZERO_BYTE;
        end else begin
            if (wr_at(ADR_IND_HIGH)) begin
                ind_r <= SFR_BUS.wdata;
            end
            if (wr_at(ADR_IRQ_CTRL)) begin
                irq_r <= SFR_BUS.wdata;
            end
            if (wr_at(ADR_BAUD_CTRL)) begin
                baud_r <= SFR_BUS.wdata & BAUD_MASK;
            end
        end
    end

    // Read decode
    always_comb begin
        hit_nxt   = 1'b1;
        rdata_nxt = 8'h00;
        if (SFR_BUS.addr == ADR_ACCUMULATOR) begin
            rdata_nxt = acc_r;
        end else if (SFR_BUS.addr == ADR_MULDIV_B) begin
            rdata_nxt = b_r;
        end else if (SFR_BUS.addr == ADR_PSW) begin
            rdata_nxt = psw_r;
        end else if (SFR_BUS.addr == ADR_STACK_POINTER) begin
            rdata_nxt = sp_r;
        end else if (SFR_BUS.addr == ADR_DPTR0_LOW) begin
            rdata_nxt = dptr0_r[7:0];
        end else if (SFR_BUS.addr == ADR_DPTR0_HIGH) begin
            rdata_nxt = dptr0_r[15:8];
        end else if (SFR_BUS.addr == ADR_DPTR1_LOW) begin
            rdata_nxt = dptr1_r[7:0];
        end else if (SFR_BUS.addr == ADR_DPTR1_HIGH) begin
            rdata_nxt = dptr1_r[15:8];
        end else if (SFR_BUS.addr == ADR_POINTER_SEL) begin
            rdata_nxt = {7'h00, dps_r};
        end else if (SFR_BUS.addr == ADR_IND_HIGH) begin
            rdata_nxt = ind_r;
        end else if (SFR_BUS.addr == ADR_IRQ_CTRL) begin
            rdata_nxt = irq_r;
        end else if (SFR_BUS.addr == ADR_BAUD_CTRL) begin
            rdata_nxt = baud_r;
        end else if (port_hit[0]) begin
            rdata_nxt = port_rd0;
        end else if (port_hit[1]) begin
            rdata_nxt = port_rd1;
        end else if (port_hit[2]) begin
            rdata_nxt = port_rd2;
        end else begin
            hit_nxt = 1'b0;
        end
    end

    // Registered outputs
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            SFR_RDATA     <= 8'h00;
            SFR_HIT       <= 1'b0;
            ACC_VALUE     <= RST_ZERO_BYTE;
            PSW_VALUE     <= RST_ZERO_BYTE;
            STACK_PTR     <= RST_STACK_PTR;
            DATA_POINTER_VALUE    <= 16'h0000;
            PROG_CNT      <= RST_PROG_CNT;
            IND_HIGH_ADDR <= RST_ZERO_BYTE;
            BANK_BASE     <= 5'h00;
            BAUD_DOUBLE   <= 1'b0;
            IRQ_CTRL      <= RST_ZERO_BYTE;
        end else begin
            SFR_RDATA     <= rdata_nxt;
            SFR_HIT       <= hit_nxt;
            ACC_VALUE     <= acc_r;
            PSW_VALUE     <= psw_r;
            STACK_PTR     <= sp_r;
            DATA_POINTER_VALUE    <= dps_r ? dptr1_r : dptr0_r;
            PROG_CNT      <= pc_r;
            IND_HIGH_ADDR <= ind_r;
            BANK_BASE <= {psw_r[PSW_BANK_HI:PSW_BANK_LO], 3'b000};
            BAUD_DOUBLE   <= baud_r[BAUD_BIT];
            IRQ_CTRL      <= irq_r;
        end
    end
endmodule // mcsfr_core

// ---- hw/mcsfr_flags.sv ----
// Arithmetic unit: add with carry, multiply, divide and the status flags.
// Assumes the core presents operands and asks for one op per cycle.
`timescale 1ns/1ns
module mcsfr_flags
    import mcsfr_pkg::*;
(
    input  wire mcsfr_alu_e  op,
    input  wire logic        cin,
    input  wire logic [7:0]  acc,
    input  wire logic [7:0]  bval,
    input  wire logic [7:0]  operand,
    output logic [7:0]       acc_nxt,
    output logic [7:0]       b_nxt,
    output logic             carry,
    output logic             half,
    output logic             ovf
);
    logic [4:0]  low_sum;
    logic [8:0]  full_sum;
    logic [7:0]  seven_sum;
    logic [15:0] prod;

    always_comb begin
        low_sum   = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
        full_sum  = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
        seven_sum = {1'b0, acc[6:0]} + {1'b0, operand[6:0]} + {7'h00, cin};
        prod      = {8'h00, acc} * {8'h00, bval};
        acc_nxt   = acc;
        b_nxt     = bval;
        carry     = 1'b0;
        half      = 1'b0;
        ovf       = 1'b0;
        case (op)
            MCSFR_ALU_ADD: begin
                acc_nxt = full_sum[7:0];
                carry   = full_sum[8];
                half    = low_sum[4];
                ovf     = full_sum[8] ^ seven_sum[7];
            end
            MCSFR_ALU_MUL: begin
                acc_nxt = prod[7:0];
                b_nxt   = prod[15:8];
                ovf     = |prod[15:8];
            end
            MCSFR_ALU_DIV: begin
                if (bval == 8'h00) begin
                    ovf = 1'b1;
                end else begin
                    acc_nxt = acc / bval;
                    b_nxt   = acc % bval;
                end
            end
            default: begin
                acc_nxt = acc;
            end
        endcase
    end
endmodule // mcsfr_flags

// ---- hw/mcsfr_pkg.sv ----
// Package: SFR addresses, reset values, field positions and carriers.
// Assumes an 8-bit direct SFR address space driven by the core.
package mcsfr_pkg;
    localparam logic [7:0] ADR_PORT0_LATCH   = 8'h80;
    localparam logic [7:0] ADR_STACK_POINTER = 8'h81;
    localparam logic [7:0] ADR_DPTR0_LOW     = 8'h82;
    localparam logic [7:0] ADR_DPTR0_HIGH    = 8'h83;
    localparam logic [7:0] ADR_DPTR1_LOW     = 8'h84;
    localparam logic [7:0] ADR_DPTR1_HIGH    = 8'h85;
    localparam logic [7:0] ADR_PORT1_LATCH   = 8'h90;
    localparam logic [7:0] ADR_PORT1_DIR     = 8'h91;
    localparam logic [7:0] ADR_POINTER_SEL   = 8'h92;
    localparam logic [7:0] ADR_PORT2_LATCH   = 8'ha0;
    localparam logic [7:0] ADR_PORT2_DIR     = 8'ha1;
    localparam logic [7:0] ADR_PORT0_DIR     = 8'ha2;
    localparam logic [7:0] ADR_IND_HIGH      = 8'hbf;
    localparam logic [7:0] ADR_IRQ_CTRL      = 8'hc0;
    localparam logic [7:0] ADR_PSW           = 8'hd0;
    localparam logic [7:0] ADR_BAUD_CTRL     = 8'hd8;
    localparam logic [7:0] ADR_ACCUMULATOR   = 8'he0;
    localparam logic [7:0] ADR_MULDIV_B      = 8'hf0;

    localparam logic [7:0]  RST_ZERO_BYTE    = 8'h00;
    localparam logic [7:0]  RST_STACK_PTR    = 8'h07;
    localparam logic [15:0] RST_PROG_CNT     = 16'h0000;
    localparam logic [7:0]  RST_PORT_LATCH   = 8'hff;
    localparam logic [7:0]  RST_PORT2_LATCH  = 8'h00;

    localparam int PSW_CARRY    = 7;
    localparam int PSW_HALF     = 6;
    localparam int PSW_USER0    = 5;
    localparam int PSW_BANK_HI  = 4;
    localparam int PSW_BANK_LO  = 3;
    localparam int PSW_OVERFLOW = 2;
    localparam int PSW_USER1    = 1;
    localparam int PSW_PARITY   = 0;
    localparam int BAUD_BIT     = 7;
    localparam logic [7:0] BAUD_MASK   = 8'h80;
    localparam logic [7:0] PSW_SW_MASK = 8'hfe;
    localparam int PORT2_PINS   = 6;
    localparam int PIN_COUNT    = 22;

    typedef enum logic [1:0] {
        MCSFR_ALU_NONE = 2'b00,
        MCSFR_ALU_ADD  = 2'b01,
        MCSFR_ALU_MUL  = 2'b10,
        MCSFR_ALU_DIV  = 2'b11
    } mcsfr_alu_e;

    // Direct SFR access from the core
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcsfr_bus_s;

    // Core execution requests
    typedef struct packed {
        mcsfr_alu_e alu_op;
        logic       alu_cin;
        logic [7:0] alu_operand;
        logic       push;
        logic       pop;
        logic       pc_inc;
        logic       pc_load;
        logic [15:0] pc_value;
        logic       data_pointer_load;
        logic [15:0] data_pointer_value;
    } mcsfr_exec_s;
endpackage

// ---- hw/mcsfr_port.sv ----
// One I/O port: data latch, direction register and pin readback.
// Assumes pin inputs already synchronous to MCLK.
`timescale 1ns/1ns
module mcsfr_port
    import mcsfr_pkg::*;
#(
    parameter int           WIDTH     = 8,
    parameter logic [7:0]   LATCH_RST = 8'hff,
    parameter logic [7:0]   LATCH_ADR = 8'h80,
    parameter logic [7:0]   DIR_ADR   = 8'ha2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire mcsfr_bus_s       bus,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0]      pin_out,
    output logic [WIDTH-1:0]      pin_oe,
    output logic                  hit,
    output logic [7:0]            rdata
);
    logic [WIDTH-1:0] latch_r;
    logic [WIDTH-1:0] dir_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_r <= LATCH_RST[WIDTH-1:0];
        end else if (bus.wr && bus.addr == LATCH_ADR) begin
            latch_r <= bus.wdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_r <= RST_ZERO_BYTE[WIDTH-1:0];
        end else if (bus.wr && bus.addr == DIR_ADR) begin
            dir_r <= bus.wdata[WIDTH-1:0];
        end
    end

    // Pins driven straight from flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_out <= latch_r;
            pin_oe  <= dir_r;
        end
    end

    always_comb begin
        hit   = 1'b1;
        rdata = 8'h00;
        if (bus.addr == LATCH_ADR) begin
            rdata[WIDTH-1:0] = pin_in;
        end else if (bus.addr == DIR_ADR) begin
            rdata[WIDTH-1:0] = dir_r;
        end else begin
            hit = 1'b0;
        end
    end
endmodule // mcsfr_port
